// *** pkg/bss_pkg.sv ***
// Package for the bit string set unit: widths, thresholds, state encoding.
// Assumes a 32-bit general register file and a byte-wide memory port.
package bss_pkg;
    localparam int          REG_W      = 32;
    localparam int          ADDR_W     = 32;
    localparam logic [31:0] RUN_LIMIT  = 32'h0000_0019; // Twenty-five
    localparam int          LUT_BYTES  = 1024;          // Pattern table size
    localparam logic [7:0]  BYTE_RST   = 8'h00;
    localparam logic [31:0] WORD_RST   = 32'h0000_0000;
    localparam logic [2:0]  BITPOS_W3  = 3'h0;

    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_CHECK = 3'b001,
        S_RDREQ = 3'b011,
        S_RDWT  = 3'b010,
        S_WRREQ = 3'b110,
        S_STEP  = 3'b111,
        S_DONE  = 3'b101
    } bss_state_type;
endpackage

// *** core/bss_unit.sv ***
// Bit string set execution unit: horizontal run and warped run instructions.
// Assumes a request/acknowledge memory port, request held until ACK, on the same clock
// and operand registers presented by the processor with a start pulse.
`timescale 1ns/100ps
module bss_unit (
    input  wire logic        CLK,
    input  wire logic        ARST_N,
    input  wire logic        START,      // One-cycle start pulse
    input  wire logic        WARPED,     // 0: horizontal, 1: warped
    input  wire logic [31:0] R0_IN,
    input  wire logic [31:0] R1_IN,
    input  wire logic [31:0] R2_IN,
    input  wire logic [31:0] R3_IN,
    output logic             BUSY,
    output logic             DONE,       // One-cycle completion pulse
    output logic             FLAG_F,
    output logic [31:0]      R0_OUT,
    output logic [31:0]      R1_OUT,
    output logic [31:0]      R2_OUT,
    output logic [31:0]      R3_OUT,
    output logic             MEM_REQ,
    output logic             MEM_WE,
    output logic [31:0]      MEM_ADDR,
    output logic [7:0]       MEM_WDATA,
    input  wire logic        MEM_ACK,
    input  wire logic [7:0]  MEM_RDATA
);
    typedef struct packed {
        bss_pkg::bss_state_type st;
        logic        warped;
        logic        busy;
        logic        done;
        logic        flag_f;
        logic [31:0] r0;
        logic [31:0] r1;
        logic [31:0] r2;
        logic [31:0] r3;
        logic [31:0] r1_start;
        logic [31:0] r2_start;
        logic [31:0] left;     // Bits still to set
        logic [31:0] cur;      // Current signed bit offset
        logic        req;
        logic        we;
        logic [31:0] addr;
        logic [7:0]  wdata;
    } bss_reg_type;

    bss_reg_type r;
    bss_reg_type next_r;
    logic [34:0] bit_addr;
    logic [2:0]  bit_pos;

    // Bit address from byte base and signed offset; three extra bits keep
    // the top of a large byte base from falling off before the shift
    always_comb begin
        bit_addr = {r.r0, 3'h0} + {{3{r.cur[31]}}, r.cur};
        bit_pos  = bit_addr[2:0];
    end

    // Next-state logic for the whole unit
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        case (r.st)
            bss_pkg::S_IDLE: begin
                if (START) begin
                    next_r.warped   = WARPED;
                    next_r.r0       = R0_IN;
                    next_r.r1       = R1_IN;
                    next_r.r2       = R2_IN;
                    next_r.r3       = R3_IN;
                    next_r.r1_start = R1_IN;
                    next_r.r2_start = R2_IN;
                    next_r.left     = R2_IN;   // Unsigned count
                    next_r.cur      = R1_IN;   // Signed offset
                    next_r.busy     = 1'b1;
                    next_r.st       = bss_pkg::S_CHECK;
                end
            end
            bss_pkg::S_CHECK: begin
                if (!r.warped && (r.left > bss_pkg::RUN_LIMIT)) begin
                    next_r.flag_f = 1'b1;
                    next_r.st     = bss_pkg::S_DONE;
                end else begin
                    if (!r.warped) begin
                        next_r.flag_f = 1'b0;
                    end
                    if (r.left == bss_pkg::WORD_RST) begin
                        next_r.st = bss_pkg::S_DONE;
                    end else begin
                        next_r.st = bss_pkg::S_RDREQ;
                    end
                end
            end
            bss_pkg::S_RDREQ: begin
                // Read the byte holding the current bit
                next_r.req  = 1'b1;
                next_r.we   = 1'b0;
                next_r.addr = bit_addr[34:3];
                next_r.st   = bss_pkg::S_RDWT;
            end
            bss_pkg::S_RDWT: begin
                if (MEM_ACK) begin
                    next_r.req   = 1'b1;
                    next_r.we    = 1'b1;
                    // Pattern bit built in place of a table fetch
                    next_r.wdata = MEM_RDATA | (8'h01 << bit_pos);
                    next_r.st    = bss_pkg::S_WRREQ;
                end
            end
            bss_pkg::S_WRREQ: begin
                if (MEM_ACK) begin
                    next_r.req = 1'b0;
                    next_r.we  = 1'b0;
                    next_r.st  = bss_pkg::S_STEP;
                end
            end
            bss_pkg::S_STEP: begin
                next_r.left = r.left - 32'h0000_0001;
                if (r.warped) begin
                    next_r.cur = r.cur + r.r3;
                end else begin
                    next_r.cur = r.cur + 32'h0000_0001;
                end
                if (r.left == 32'h0000_0001) begin
                    next_r.st = bss_pkg::S_DONE;
                end else begin
                    next_r.st = bss_pkg::S_RDREQ;
                end
            end
            bss_pkg::S_DONE: begin
                if (r.warped) begin
                    next_r.r1 = r.cur - r.r3;  // Final bit offset
                    next_r.r2 = bss_pkg::WORD_RST;
                    if (r.r2_start == bss_pkg::WORD_RST) begin
                        next_r.r1 = r.r1_start;
                    end
                end else begin
                    next_r.r1 = r.r1_start;
                    next_r.r2 = r.r2_start;
                end
                next_r.busy = 1'b0;
                next_r.done = 1'b1;
                next_r.st   = bss_pkg::S_IDLE;
            end
            default: begin
                next_r = '0;
            end
        endcase
    end

    // State register
    always_ff @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Outputs straight from the state
    always_comb begin
        BUSY      = r.busy;
        DONE      = r.done;
        FLAG_F    = r.flag_f;
        R0_OUT    = r.r0;
        R1_OUT    = r.r1;
        R2_OUT    = r.r2;
        R3_OUT    = r.r3;
        MEM_REQ   = r.req;
        MEM_WE    = r.we;
        MEM_ADDR  = r.addr;
        MEM_WDATA = r.wdata;
    end

    // Limit decision: over the limit ends quickly with F set and no access
    property p_over_limit;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_CHECK && !r.warped && r.left > bss_pkg::RUN_LIMIT)
        |=> (r.flag_f && r.st == bss_pkg::S_DONE) ##1 DONE;
    endproperty
    a_over_limit: assert property (p_over_limit)
        else $error("over limit");

    property p_under_limit;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_CHECK && !r.warped &&
         r.left <= bss_pkg::RUN_LIMIT) |=> !FLAG_F;
    endproperty
    a_under_limit: assert property (p_under_limit)
        else $error("F not cleared");

    property p_over_quiet;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_CHECK && !r.warped && r.left > bss_pkg::RUN_LIMIT)
        |=> (!MEM_REQ && !MEM_WE) [*2];
    endproperty
    a_over_quiet: assert property (p_over_quiet)
        else $error("access after over limit");

    // Operands taken at start: count unsigned, offset signed
    property p_start_load;
        @(posedge CLK) disable iff (!ARST_N)
        (START && r.st == bss_pkg::S_IDLE) |=>
        (r.left == $past(R2_IN) && r.cur == $past(R1_IN) && BUSY);
    endproperty
    a_start_load: assert property (p_start_load)
        else $error("operands not taken");

    // Memory port: each byte read, then rewritten with the run bit added
    property p_write_sets_bit;
        @(posedge CLK) disable iff (!ARST_N)
        (MEM_REQ && MEM_WE) |-> MEM_WDATA[bit_pos];
    endproperty
    a_write_sets_bit: assert property (p_write_sets_bit)
        else $error("bit not set");

    property p_keep_bits;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_RDWT && MEM_ACK) |=>
        (MEM_WDATA == ($past(MEM_RDATA) | (8'h01 << bit_pos)));
    endproperty
    a_keep_bits: assert property (p_keep_bits)
        else $error("bits lost");

    property p_req_hold;
        @(posedge CLK) disable iff (!ARST_N)
        (MEM_REQ && !MEM_ACK) |=>
        (MEM_REQ && $stable(MEM_ADDR) && $stable(MEM_WE) &&
         $stable(MEM_WDATA));
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("request dropped before ack");

    property p_addr_form;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_RDREQ) |=>
        (MEM_ADDR == r.r0 + 32'($signed(r.cur) >>> 3) && !MEM_WE);
    endproperty
    a_addr_form: assert property (p_addr_form)
        else $error("wrong byte address");

    // Stepping between bits
    property p_warp_step;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_STEP && r.warped) |=>
        (r.cur == $past(r.cur) + r.r3);
    endproperty
    a_warp_step: assert property (p_warp_step)
        else $error("bad warp step");

    property p_horiz_step;
        @(posedge CLK) disable iff (!ARST_N)
        (r.st == bss_pkg::S_STEP && !r.warped) |=>
        (r.cur == $past(r.cur) + 32'h0000_0001);
    endproperty
    a_horiz_step: assert property (p_horiz_step)
        else $error("run bits not adjacent");

    // Completion: operand registers and the done pulse
    property p_horiz_restore;
        @(posedge CLK) disable iff (!ARST_N)
        (DONE && !r.warped) |->
        (R1_OUT == r.r1_start && R2_OUT == r.r2_start);
    endproperty
    a_horiz_restore: assert property (p_horiz_restore)
        else $error("regs changed");

    property p_warp_end;
        @(posedge CLK) disable iff (!ARST_N)
        (DONE && r.warped) |-> (R2_OUT == 32'h0 && r.left == 32'h0);
    endproperty
    a_warp_end: assert property (p_warp_end)
        else $error("count not zero");

    property p_no_write_over;
        @(posedge CLK) disable iff (!ARST_N)
        (r.flag_f && !r.warped && r.st == bss_pkg::S_DONE) |-> !MEM_REQ;
    endproperty
    a_no_write_over: assert property (p_no_write_over)
        else $error("wrote on over");

    property p_done_pulse;
        @(posedge CLK) disable iff (!ARST_N)
        DONE |-> (!BUSY && r.st == bss_pkg::S_IDLE) ##1 !DONE;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done not a single pulse");

    // Main scenarios reached
    c_horiz: cover property (@(posedge CLK) DONE && !r.warped && !FLAG_F);
    c_over:  cover property (@(posedge CLK) DONE && FLAG_F);
    c_warp:  cover property (@(posedge CLK) DONE && r.warped);
    c_zero:  cover property (@(posedge CLK) DONE && r.r2_start == 32'h0);
    c_slow:  cover property (@(posedge CLK) MEM_REQ && !MEM_ACK ##1 !MEM_ACK);
endmodule // bss_unit

// *** verif/bss_mem_model.sv ***
// Byte memory behind the unit's memory port, 32 bytes, address wraps.
// Assumes requests held until ACK; WAIT_CYC adds wait cycles per access.
`timescale 1ns/100ps
module bss_mem_model (
    input  wire logic       CLK,
    input  wire logic       ARST_N,
    input  wire logic       REQ,
    input  wire logic       WE,
    input  wire logic [31:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic [3:0] WAIT_CYC,
    output logic            ACK,
    output logic [7:0]      RDATA
);
    logic [7:0] mem [0:31];
    logic [3:0] cnt;

    // One-cycle ACK per access; read data is scrambled outside ACK
    always @(posedge CLK or negedge ARST_N) begin
        if (!ARST_N) begin
            ACK   <= 1'b0;
            cnt   <= 4'h0;
            RDATA <= 8'h00;
        end else if (REQ && !ACK && cnt >= WAIT_CYC) begin
            ACK <= 1'b1;
            cnt <= 4'h0;
            if (WE)
                mem[ADDR[4:0]] <= WDATA;
            else
                RDATA <= mem[ADDR[4:0]];
        end else begin
            ACK   <= 1'b0;
            RDATA <= ~RDATA;
            cnt   <= (REQ && !ACK) ? cnt + 4'h1 : 4'h0;
        end
    end
endmodule // bss_mem_model

// *** verif/bit_string_set_unit_test.sv ***
// Self-checking bench for the bit string set unit.
// Assumes the byte memory model answers the unit's memory port.
`timescale 1ns/100ps
module bit_string_set_unit_test;
    logic        CLK = 1'b0, ARST_N = 1'b0, START = 1'b0, WARPED = 1'b0;
    logic [31:0] R0_IN = 32'h0, R1_IN = 32'h0, R2_IN = 32'h0, R3_IN = 32'h0;
    logic        BUSY, DONE, FLAG_F, MEM_REQ, MEM_WE, MEM_ACK;
    logic [31:0] R0_OUT, R1_OUT, R2_OUT, R3_OUT, MEM_ADDR;
    logic [7:0]  MEM_WDATA, MEM_RDATA;
    logic [3:0]  wait_cyc = 4'h0;
    logic [7:0]  exp_mem [0:31];
    int          fails = 0, n_tests = 0, cyc;

    bss_unit bss_unit_inst (.CLK(CLK), .ARST_N(ARST_N), .START(START),
        .WARPED(WARPED), .R0_IN(R0_IN), .R1_IN(R1_IN), .R2_IN(R2_IN),
        .R3_IN(R3_IN), .BUSY(BUSY), .DONE(DONE), .FLAG_F(FLAG_F),
        .R0_OUT(R0_OUT), .R1_OUT(R1_OUT), .R2_OUT(R2_OUT), .R3_OUT(R3_OUT),
        .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR),
        .MEM_WDATA(MEM_WDATA), .MEM_ACK(MEM_ACK), .MEM_RDATA(MEM_RDATA));
    bss_mem_model bss_mem_model_inst (.CLK(CLK), .ARST_N(ARST_N),
        .REQ(MEM_REQ), .WE(MEM_WE), .ADDR(MEM_ADDR), .WDATA(MEM_WDATA),
        .WAIT_CYC(wait_cyc), .ACK(MEM_ACK), .RDATA(MEM_RDATA));

    // Clock at 100 MHz
    always #5 CLK = ~CLK;

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Fill memory and expectation with the same background pattern
    task fill();
        for (int i = 0; i < 32; i++) begin
            bss_mem_model_inst.mem[i] = 8'h24 ^ 8'(i);
            exp_mem[i] = 8'h24 ^ 8'(i);
        end
    endtask

    // Issue one instruction and count edges until DONE
    task run(input logic w, input logic [31:0] a, b, c, d);
        @(posedge CLK);
        START <= 1'b1; WARPED <= w;
        R0_IN <= a; R1_IN <= b; R2_IN <= c; R3_IN <= d;
        @(posedge CLK);
        START <= 1'b0;
        cyc = 0;
        #1;
        check(32'(BUSY), 32'h1);
        while (DONE !== 1'b1 && cyc < 2000) begin
            @(posedge CLK);
            #1;
            cyc++;
        end
        check(32'(DONE), 32'h1);
        check(32'(BUSY), 32'h0);
    endtask

    task mem_cmp();
        for (int i = 0; i < 32; i++)
            check(32'(bss_mem_model_inst.mem[i]), 32'(exp_mem[i]));
    endtask

    // Limit count, negative offset, run across four bytes
    task t_horiz_limit();
        int a;
        fill();
        for (int i = 0; i < 25; i++) begin
            a = 4 * 8 - 5 + i;
            exp_mem[a >> 3][a & 7] = 1'b1;
        end
        run(1'b0, 32'h4, 32'hffff_fffb, 32'd25, 32'h100);
        check(32'(FLAG_F), 32'h0);
        mem_cmp();
        check(R0_OUT, 32'h4);
        check(R1_OUT, 32'hffff_fffb);
        check(R2_OUT, 32'd25);
        check(R3_OUT, 32'h100);
    endtask

    // One over the limit: flag set, memory untouched, quick finish
    task t_horiz_over();
        fill();
        run(1'b0, 32'h2, 32'h1, 32'd26, 32'h100);
        check(32'(FLAG_F), 32'h1);
        check(32'(cyc <= 3), 32'h1);
        mem_cmp();
    endtask

    // Negative warp with slow memory, stepping down through bytes
    task t_warped();
        int a;
        fill();
        wait_cyc = 4'h2;
        for (int i = 0; i < 4; i++) begin
            a = 8 * 8 + 3 - 9 * i;
            exp_mem[a >> 3][a & 7] = 1'b1;
        end
        run(1'b1, 32'h8, 32'h3, 32'd4, 32'hffff_fff7);
        mem_cmp();
        check(R0_OUT, 32'h8);
        check(R1_OUT, 32'hffff_ffe8);
        check(R2_OUT, 32'h0);
        check(R3_OUT, 32'hffff_fff7);
        check(32'(FLAG_F), 32'h1);
        wait_cyc = 4'h0;
    endtask

    // Zero counts in both modes: nothing written, operands as promised
    task t_zero_count();
        fill();
        run(1'b0, 32'h3, 32'h5, 32'h0, 32'h100);
        check(32'(FLAG_F), 32'h0);
        check(R2_OUT, 32'h0);
        run(1'b1, 32'h3, 32'h5, 32'h0, 32'h9);
        check(R1_OUT, 32'h5);
        check(R2_OUT, 32'h0);
        mem_cmp();
    endtask

    task end_of_test();
        $display("Mismatches %0d of %0d compares", fails, n_tests);
        if (fails == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(posedge CLK);
        ARST_N <= 1'b1;
        t_horiz_over();
        t_warped();
        t_horiz_limit();
        t_zero_count();
        end_of_test();
    end

    // Watchdog against a hung handshake
    initial begin
        #100000;
        fails++;
        end_of_test();
    end
endmodule // bit_string_set_unit_test
